// ==== src/isr_top.sv ====
// Operation status group, status summary byte, error and output queues, reset and interface settings.
`timescale 1ns/100ps
`default_nettype none
`include "isr_regs.svh"

// Notes on behaviour
// - Operation event latches events, is read-only, and clears when read.
// - Operation enable is read/write and selects events feeding the summary.
// - Condition bit 0 while calibrating; bit 1 while warming up.
// - Condition bit 2 when an emergency stop is active.
// - Condition bit 4 while a cell measurement runs.
// - Condition bit 8 when cell configuration changed since last test.
// - Condition bit 9 when inhibit has disconnected all channels.
// - Condition bit 12 when reference temperature unregulated during test initiate.
// - Condition bit 13 while the error queue holds entries.
// - Summary bit 1 reflects pending alarm events, removed by alarm event read.
// - Summary bit 2 set whenever the error queue is not empty.
// - Summary bit 4 shows response data waiting in the output buffer.
// - Summary bit 6 is master summary and raises service request.
// - Summary bit 7 set when any enabled operation event is set.
// - Master summary is unlatched OR of summary bits masked by request enable.
// - Summary byte query returns bits without clearing any.
// - Error queue is first-in first-out until read by the error query.
// - On overflow the newest entry is replaced by the overflow code.
// - Output queue is first-in first-out; bit 4 set while not empty.
// - Reset command restores test, interval, byte order, inhibit, pin defaults.
// - Reset command leaves interface enables, addressing and naming unchanged.
// - Interface changes apply after power cycle; network changes after restart.
// - Condition bits follow instrument state live, without latching.
// - A set event bit ignores further occurrences of its event.
// - Error queue cleared by power cycle, not by reset command.
module isr_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CALIBRATING,
  input wire logic WARMING_UP,
  input wire logic EMERGENCY_STOP,
  input wire logic MEASURING,
  input wire logic CONFIG_CHANGED,
  input wire logic INHIBIT_DISCONNECT,
  input wire logic TEMP_UNREGULATED,
  input wire logic INIT_RUNNING,
  input wire logic ALARM_SUMMARY,
  input wire logic CMD_VALID,
  input wire isr_pkg::isr_cmd_t CMD_CODE,
  input wire logic [15:0] CMD_DATA,
  input wire logic ERR_PUSH,
  input wire logic [15:0] ERR_CODE,
  input wire logic OUT_POP,
  input wire logic [2:0] NV_IFACE,
  output logic [15:0] OUT_DATA,
  output logic OUT_VALID,
  output logic [7:0] STATUS_BYTE,
  output logic SERVICE_REQUEST,
  output logic [15:0] TEST_DURATION,
  output logic [15:0] TEST_INTERVAL,
  output logic BYTE_SWAPPED,
  output logic INHIBIT_MODE,
  output logic DIG_PIN_OUTPUT,
  output logic DIG_PIN_NEGATIVE,
  output logic [2:0] IFACE_ACTIVE,
  output logic [2:0] IFACE_PENDING,
  output logic [1:0] NET_ACTIVE
);
  logic [15:0] oper_cond;
  logic [15:0] cond_prev;
  logic [15:0] cond_rise;
  logic [15:0] oper_event;
  logic [15:0] oper_enable;
  logic [7:0] sre;
  logic [7:0] stb_now;
  logic master_summary;
  logic [4:0] err_count;
  logic [4:0] err_wr;
  logic [4:0] err_rd;
  logic err_ovf;
  logic err_pop;
  logic err_push_ok;
  logic err_over;
  logic [3:0] out_count;
  logic [2:0] out_wr;
  logic [2:0] out_rd;
  logic out_push;
  logic out_pop_ok;
  logic out_popped;
  logic rsp_go;
  logic rsp_err;
  logic [15:0] rsp_word;
  logic [15:0] duration;
  logic [15:0] interval;
  logic [3:0] flags;
  logic [2:0] iface_pending;
  logic [2:0] iface_active;
  logic [1:0] net_pending;
  logic [1:0] net_active;
  logic boot_done;

  isr_mem_if #(.AW(`ISR_ERRQ_AW), .DW(16)) errq ();
  isr_mem_if #(.AW(`ISR_OUTQ_AW), .DW(16)) outq ();

  isr_mem #(.AW(`ISR_ERRQ_AW), .DW(16), .DEPTH(20)) u_errq (
    .clk(CLK),
    .nrst(NRST),
    .port(errq)
  );

  isr_mem #(.AW(`ISR_OUTQ_AW), .DW(16), .DEPTH(8)) u_outq (
    .clk(CLK),
    .nrst(NRST),
    .port(outq)
  );

  function automatic logic isr_is_cmd(input logic valid, input isr_pkg::isr_cmd_t code,
                                      input isr_pkg::isr_cmd_t want);
    isr_is_cmd = valid && (code == want);
  endfunction

  function automatic logic [4:0] isr_err_next(input logic [4:0] ptr);
    isr_err_next = (ptr == `ISR_ERRQ_LAST) ? 5'h00 : 5'(ptr + 5'h01);
  endfunction

  always_comb begin
    oper_cond = 16'h0000;
    oper_cond[`ISR_OPER_CAL] = CALIBRATING;
    oper_cond[`ISR_OPER_WARMUP] = WARMING_UP;
    oper_cond[`ISR_OPER_ESTOP] = EMERGENCY_STOP;
    oper_cond[`ISR_OPER_MEAS] = MEASURING;
    oper_cond[`ISR_OPER_CFGCHG] = CONFIG_CHANGED;
    oper_cond[`ISR_OPER_INHIBIT] = INHIBIT_DISCONNECT;
    oper_cond[`ISR_OPER_TEMPUNREG] = TEMP_UNREGULATED && INIT_RUNNING;
    oper_cond[`ISR_OPER_GLOBERR] = (err_count != 5'h00);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cond_prev <= 16'h0000;
    end else begin
      cond_prev <= oper_cond;
    end
  end

  assign cond_rise = oper_cond & ~cond_prev;

  // set bits ignore repeats
  // A rise in the reading cycle is kept, so the clear never swallows a fresh event.
  for (genvar g = 0; g < 16; g++) begin : g_event
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        oper_event[g] <= 1'b0;
      end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_READ_EVENT)) begin
        oper_event[g] <= cond_rise[g];
      end else if (cond_rise[g]) begin
        oper_event[g] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      oper_enable <= 16'h0000;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_WRITE_ENABLE)) begin
      oper_enable <= CMD_DATA & `ISR_OPER_MASK;
    end
  end

  // Bit 6 of the request enable has no meaning and is never stored.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sre <= 8'h00;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_WRITE_SRE)) begin
      sre <= CMD_DATA[7:0] & `ISR_STB_MASK;
    end
  end

  always_comb begin
    stb_now = 8'h00;
    stb_now[`ISR_STB_ALARM] = ALARM_SUMMARY;
    stb_now[`ISR_STB_ERRQ] = (err_count != 5'h00);
    stb_now[`ISR_STB_MAV] = (out_count != 4'h0);
    stb_now[`ISR_STB_OPER] = |(oper_event & oper_enable);
    master_summary = |(stb_now & sre);
    stb_now[`ISR_STB_MSS] = master_summary;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      STATUS_BYTE <= 8'h00;
      SERVICE_REQUEST <= 1'b0;
    end else begin
      STATUS_BYTE <= stb_now;
      SERVICE_REQUEST <= master_summary;
    end
  end

  assign err_pop = isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_READ_ERROR) && (err_count != 5'h00);
  assign err_push_ok = ERR_PUSH && ((err_count != `ISR_ERRQ_DEPTH) || err_pop);
  assign err_over = ERR_PUSH && (err_count == `ISR_ERRQ_DEPTH) && !err_pop && !err_ovf;

  always_comb begin
    errq.we = err_push_ok || err_over;
    errq.waddr = err_wr;
    errq.wdata = ERR_CODE;
    if (err_over) begin
      errq.waddr = (err_wr == 5'h00) ? `ISR_ERRQ_LAST : 5'(err_wr - 5'h01);
      errq.wdata = `ISR_ERR_OVERFLOW;
    end
    errq.raddr = err_rd;
  end

  // power cycle empties the queue at once; reads remove one entry each
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      err_count <= 5'h00;
      err_wr <= 5'h00;
      err_rd <= 5'h00;
      err_ovf <= 1'b0;
    end else begin
      if (err_push_ok) begin
        err_wr <= isr_err_next(err_wr);
      end
      if (err_pop) begin
        err_rd <= isr_err_next(err_rd);
      end
      if (err_push_ok && !err_pop) begin
        err_count <= 5'(err_count + 5'h01);
      end else if (err_pop && !err_push_ok) begin
        err_count <= 5'(err_count - 5'h01);
      end
      if (err_over) begin
        err_ovf <= 1'b1;
      end else if (err_pop) begin
        err_ovf <= 1'b0;
      end
    end
  end

  // summary query reads without clearing
  // Query answers are staged one cycle so that error text can come from the registered memory read.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rsp_go <= 1'b0;
      rsp_err <= 1'b0;
      rsp_word <= 16'h0000;
    end else begin
      rsp_go <= 1'b0;
      rsp_err <= 1'b0;
      if (CMD_VALID) begin
        case (CMD_CODE)
          isr_pkg::ISR_CMD_READ_COND: begin
            rsp_go <= 1'b1;
            rsp_word <= oper_cond;
          end
          isr_pkg::ISR_CMD_READ_EVENT: begin
            rsp_go <= 1'b1;
            rsp_word <= oper_event;
          end
          isr_pkg::ISR_CMD_READ_ENABLE: begin
            rsp_go <= 1'b1;
            rsp_word <= oper_enable;
          end
          isr_pkg::ISR_CMD_READ_STB: begin
            rsp_go <= 1'b1;
            rsp_word <= {8'h00, stb_now};
          end
          isr_pkg::ISR_CMD_READ_SRE: begin
            rsp_go <= 1'b1;
            rsp_word <= {8'h00, sre};
          end
          isr_pkg::ISR_CMD_READ_ERROR: begin
            rsp_go <= 1'b1;
            rsp_err <= err_pop;
            rsp_word <= `ISR_ERR_NONE;
          end
          default: begin
            rsp_go <= 1'b0;
          end
        endcase
      end
    end
  end

  // output queue order
  // A response arriving at a full output queue is dropped; the controller must drain it.
  assign out_push = rsp_go && (out_count != `ISR_OUTQ_DEPTH);
  assign out_pop_ok = OUT_POP && (out_count != 4'h0) && !out_popped;

  always_comb begin
    outq.we = out_push;
    outq.waddr = out_wr;
    outq.wdata = rsp_err ? errq.rdata : rsp_word;
    outq.raddr = out_rd;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      out_count <= 4'h0;
      out_wr <= 3'h0;
      out_rd <= 3'h0;
      out_popped <= 1'b0;
      OUT_VALID <= 1'b0;
    end else begin
      if (out_push) begin
        out_wr <= 3'(out_wr + 3'h1);
      end
      if (out_pop_ok) begin
        out_rd <= 3'(out_rd + 3'h1);
      end
      if (out_push && !out_pop_ok) begin
        out_count <= 4'(out_count + 4'h1);
      end else if (out_pop_ok && !out_push) begin
        out_count <= 4'(out_count - 4'h1);
      end
      out_popped <= out_pop_ok;
      OUT_VALID <= (out_count != 4'h0) && !out_pop_ok;
    end
  end

  assign OUT_DATA = outq.rdata;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      duration <= `ISR_DURATION_SEC;
      interval <= `ISR_INTERVAL_SEC;
      flags <= `ISR_FLAGS_RESET;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_RESET)) begin
      duration <= `ISR_DURATION_SEC;
      interval <= `ISR_INTERVAL_SEC;
      flags <= `ISR_FLAGS_RESET;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_SET_DURATION)) begin
      duration <= CMD_DATA;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_SET_INTERVAL)) begin
      interval <= CMD_DATA;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_SET_FLAGS)) begin
      flags <= CMD_DATA[3:0];
    end
  end

  assign TEST_DURATION = duration;
  assign TEST_INTERVAL = interval;
  assign BYTE_SWAPPED = flags[0];
  assign INHIBIT_MODE = flags[1];
  assign DIG_PIN_OUTPUT = flags[2];
  assign DIG_PIN_NEGATIVE = flags[3];

  // interface settings ignore the reset command
  // enables apply only at power-up
  // The stored enables are sampled once after reset release, which stands in for the power cycle.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      boot_done <= 1'b0;
      iface_active <= `ISR_IFACE_RESET;
      iface_pending <= `ISR_IFACE_RESET;
    end else if (!boot_done) begin
      boot_done <= 1'b1;
      iface_active <= NV_IFACE;
      iface_pending <= NV_IFACE;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_SET_IFACE)) begin
      iface_pending <= CMD_DATA[2:0];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      net_pending <= `ISR_NET_RESET;
      net_active <= `ISR_NET_RESET;
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_SET_NET)) begin
      net_pending <= CMD_DATA[1:0];
    end else if (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_NET_RESTART)) begin
      net_active <= net_pending;
    end
  end

  assign IFACE_ACTIVE = iface_active;
  assign IFACE_PENDING = iface_pending;
  assign NET_ACTIVE = net_active;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  event_read_clear_a: assert property (
    isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_READ_EVENT) |=> oper_event == $past(cond_rise))
    else $error("operation event not cleared by read");
  rise_sets_event_a: assert property (
    (|cond_rise) |=> ((oper_event & $past(cond_rise)) == $past(cond_rise)))
    else $error("condition rise did not set event");
  unused_bits_zero_a: assert property (
    ((oper_event | oper_enable | oper_cond) & ~`ISR_OPER_MASK) == 16'h0000 && (STATUS_BYTE & 8'h29) == 8'h00)
    else $error("unused bit reads nonzero");
  global_error_a: assert property (
    oper_cond[`ISR_OPER_GLOBERR] == (err_count != 5'h00))
    else $error("global error bit wrong");
  global_error_clear_a: assert property (
    (err_pop && !err_push_ok && err_count == 5'h01) |=> !oper_cond[`ISR_OPER_GLOBERR])
    else $error("global error bit stayed set after last entry was read");
  errq_summary_a: assert property (
    (err_count != 5'h00) |=> STATUS_BYTE[`ISR_STB_ERRQ])
    else $error("error queue summary missing");
  mav_follows_a: assert property (
    out_push ##1 1'b1 |=> STATUS_BYTE[`ISR_STB_MAV])
    else $error("message available missing after push");
  mss_request_a: assert property (
    (sre[`ISR_STB_OPER] && stb_now[`ISR_STB_OPER]) |=> SERVICE_REQUEST && STATUS_BYTE[`ISR_STB_MSS])
    else $error("enabled summary did not raise request");
  overflow_mark_a: assert property (
    err_over |=> err_ovf && err_count == `ISR_ERRQ_DEPTH ##1 u_errq.store[$past(errq.waddr, 2)] == `ISR_ERR_OVERFLOW)
    else $error("overflow code not stored");
  reset_defaults_a: assert property (
    isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_RESET) |=>
      duration == 16'h012C && interval == 16'h0001 && flags == 4'h1)
    else $error("reset command defaults wrong");
  reset_keeps_iface_a: assert property (
    (boot_done && isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_RESET)) |=>
      $stable(iface_pending) && $stable(net_pending) && $stable(err_count) || $past(ERR_PUSH))
    else $error("reset command disturbed interface or error queue");
  iface_power_a: assert property (
    boot_done |=> $stable(iface_active))
    else $error("interface enable changed without power cycle");

  cover property (err_over);
  cover property (isr_is_cmd(CMD_VALID, CMD_CODE, isr_pkg::ISR_CMD_READ_EVENT) && (|oper_event));
  cover property ($rose(SERVICE_REQUEST));
  cover property (out_count == `ISR_OUTQ_DEPTH);
endmodule
`default_nettype wire

// ==== src/isr_regs.svh ====
// Bit positions, masks, reset values and queue sizes of the status reporting block.
`ifndef ISR_REGS_SVH
`define ISR_REGS_SVH

// Operation condition/event/enable bit positions.
`define ISR_OPER_CAL 0
`define ISR_OPER_WARMUP 1
`define ISR_OPER_ESTOP 2
`define ISR_OPER_MEAS 4
`define ISR_OPER_CFGCHG 8
`define ISR_OPER_INHIBIT 9
`define ISR_OPER_TEMPUNREG 12
`define ISR_OPER_GLOBERR 13
`define ISR_OPER_MASK 16'h3317

// Status summary byte bit positions.
`define ISR_STB_ALARM 1
`define ISR_STB_ERRQ 2
`define ISR_STB_MAV 4
`define ISR_STB_MSS 6
`define ISR_STB_OPER 7
`define ISR_STB_MASK 8'h96

// Queue geometry and the overflow code (-350 in two's complement).
`define ISR_ERRQ_AW 5
`define ISR_ERRQ_DEPTH 5'h14
`define ISR_ERRQ_LAST 5'h13
`define ISR_ERR_OVERFLOW 16'hFEA2
`define ISR_ERR_NONE 16'h0000
`define ISR_OUTQ_AW 3
`define ISR_OUTQ_DEPTH 4'h8

// Reset-command defaults; times are held in seconds.
`define ISR_DURATION_MIN 16'h0005
`define ISR_SEC_PER_MIN 16'h003C
`define ISR_DURATION_SEC (16'(`ISR_DURATION_MIN * `ISR_SEC_PER_MIN))
`define ISR_INTERVAL_SEC 16'h0001
// Flags: bit0 byte order swapped, bit1 inhibit mode, bit2 pin is output, bit3 negative polarity.
`define ISR_FLAGS_RESET 4'h1

// Interface settings: bit0 LAN, bit1 USB, bit2 network services; net bit0 DHCP, bit1 auto IP.
`define ISR_IFACE_RESET 3'h7
`define ISR_NET_RESET 2'h3

`endif

// ==== src/isr_pkg.sv ====
// Types shared by the status reporting block.
package isr_pkg;
  typedef enum logic [3:0] {
    ISR_CMD_NOP = 4'h0,
    ISR_CMD_READ_COND = 4'h1,
    ISR_CMD_READ_EVENT = 4'h2,
    ISR_CMD_WRITE_ENABLE = 4'h3,
    ISR_CMD_READ_ENABLE = 4'h4,
    ISR_CMD_READ_STB = 4'h5,
    ISR_CMD_WRITE_SRE = 4'h6,
    ISR_CMD_READ_SRE = 4'h7,
    ISR_CMD_READ_ERROR = 4'h8,
    ISR_CMD_RESET = 4'h9,
    ISR_CMD_SET_DURATION = 4'hA,
    ISR_CMD_SET_INTERVAL = 4'hB,
    ISR_CMD_SET_FLAGS = 4'hC,
    ISR_CMD_SET_IFACE = 4'hD,
    ISR_CMD_SET_NET = 4'hE,
    ISR_CMD_NET_RESTART = 4'hF
  } isr_cmd_t;
endpackage

// ==== src/isr_mem_if.sv ====
// Write and read port bundle between the queue control logic and its memory.
`timescale 1ns/100ps
`default_nettype none
interface isr_mem_if #(parameter int AW = 5, parameter int DW = 16) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== src/isr_mem.sv ====
// Small queue memory with one write port and a registered read port.
`timescale 1ns/100ps
`default_nettype none
module isr_mem #(parameter int AW = 5, parameter int DW = 16, parameter int DEPTH = 20) (
  input wire logic clk,
  input wire logic nrst,
  isr_mem_if.mem port
);
  logic [DW-1:0] store [DEPTH];

  always_ff @(posedge clk) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
  end

  // Read data is registered so that it can drive a top-level output directly.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port.rdata <= '0;
    end else begin
      port.rdata <= store[port.raddr];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/isr_ctrl_model.sv ====
// Remote controller model that collects answers from the output queue.
`timescale 1ns/100ps
`default_nettype none
module isr_ctrl_model (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic hold,
  input wire logic OUT_VALID,
  input wire logic [15:0] OUT_DATA,
  output logic OUT_POP,
  output logic [15:0] resp_data,
  output int resp_count
);
  always @(negedge CLK or negedge NRST) begin
    if (!NRST) begin
      OUT_POP <= 1'b0;
      resp_data <= 16'h0000;
      resp_count <= 0;
    end else if (OUT_VALID && !OUT_POP && !hold) begin
      OUT_POP <= 1'b1;
      resp_data <= OUT_DATA;
      resp_count <= resp_count + 1;
    end else begin
      OUT_POP <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/instrument_status_reporting_tb_top.sv ====
// Self-checking bench for the status reporting block.
`timescale 1ns/100ps
`default_nettype none
module instrument_status_reporting_tb_top;
  logic CLK, NRST, cmd_valid, err_push, hold, OUT_POP, OUT_VALID, SERVICE_REQUEST;
  logic BYTE_SWAPPED, INHIBIT_MODE, DIG_PIN_OUTPUT, DIG_PIN_NEGATIVE;
  logic [8:0] st;
  isr_pkg::isr_cmd_t cmd_code;
  logic [15:0] cmd_data, err_code, OUT_DATA, TEST_DURATION, TEST_INTERVAL, resp_data, r, flags;
  logic [7:0] STATUS_BYTE;
  logic [2:0] nv_iface, IFACE_ACTIVE, IFACE_PENDING;
  logic [1:0] NET_ACTIVE;
  int resp_count, fail_count, tests_run, cycles;
  assign flags = {12'h000, DIG_PIN_NEGATIVE, DIG_PIN_OUTPUT, INHIBIT_MODE, BYTE_SWAPPED};

  isr_top i_isr_top (.CLK(CLK), .NRST(NRST), .CALIBRATING(st[0]), .WARMING_UP(st[1]),
    .EMERGENCY_STOP(st[2]), .MEASURING(st[3]), .CONFIG_CHANGED(st[4]), .INHIBIT_DISCONNECT(st[5]),
    .TEMP_UNREGULATED(st[6]), .INIT_RUNNING(st[7]), .ALARM_SUMMARY(st[8]), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .ERR_PUSH(err_push), .ERR_CODE(err_code),
    .OUT_POP(OUT_POP), .NV_IFACE(nv_iface), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
    .STATUS_BYTE(STATUS_BYTE), .SERVICE_REQUEST(SERVICE_REQUEST), .TEST_DURATION(TEST_DURATION),
    .TEST_INTERVAL(TEST_INTERVAL), .BYTE_SWAPPED(BYTE_SWAPPED), .INHIBIT_MODE(INHIBIT_MODE),
    .DIG_PIN_OUTPUT(DIG_PIN_OUTPUT), .DIG_PIN_NEGATIVE(DIG_PIN_NEGATIVE),
    .IFACE_ACTIVE(IFACE_ACTIVE), .IFACE_PENDING(IFACE_PENDING), .NET_ACTIVE(NET_ACTIVE));

  isr_ctrl_model i_isr_ctrl_model (.CLK(CLK), .NRST(NRST), .hold(hold), .OUT_VALID(OUT_VALID),
    .OUT_DATA(OUT_DATA), .OUT_POP(OUT_POP), .resp_data(resp_data), .resp_count(resp_count));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic conclude();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input isr_pkg::isr_cmd_t c, input logic [15:0] d);
    @(negedge CLK);
    cmd_code = c;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge CLK);
    cmd_valid = 1'b0;
  endtask

  // An answer that never arrives comes back unknown, so any compare on it fails.
  task automatic ask(input isr_pkg::isr_cmd_t c);
    int n;
    n = resp_count;
    cmd(c, 16'h0000);
    for (int i = 0; i < 30 && resp_count == n; i++) @(posedge CLK);
    r = (resp_count == n) ? 16'hxxxx : resp_data;
    @(negedge CLK);
  endtask

  task automatic push(input logic [15:0] c);
    @(negedge CLK);
    err_code = c;
    err_push = 1'b1;
    @(negedge CLK);
    err_push = 1'b0;
  endtask

  task automatic t_reset();
    chk(TEST_DURATION, 16'h012C);
    chk(TEST_INTERVAL, 16'h0001);
    chk(flags, 16'h0001);
    chk({13'h0000, IFACE_ACTIVE}, 16'h0005);
    chk({14'h0000, NET_ACTIVE}, 16'h0003);
    chk({8'h00, STATUS_BYTE}, 16'h0000);
  endtask

  task automatic t_oper();
    logic [15:0] w [6];
    w = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0100, 16'h0200};
    for (int i = 0; i < 6; i++) begin
      st[i] = 1'b1;
      ask(isr_pkg::ISR_CMD_READ_COND);
      chk(r, w[i]);
      ask(isr_pkg::ISR_CMD_READ_EVENT);
      chk(r, w[i]);
      ask(isr_pkg::ISR_CMD_READ_EVENT);
      chk(r, 16'h0000);
      st[i] = 1'b0;
      ask(isr_pkg::ISR_CMD_READ_COND);
      chk(r, 16'h0000);
    end
    st[6] = 1'b1;
    ask(isr_pkg::ISR_CMD_READ_COND);
    chk(r, 16'h0000);
    st[7] = 1'b1;
    ask(isr_pkg::ISR_CMD_READ_COND);
    chk(r, 16'h1000);
    st[7:6] = 2'b00;
    ask(isr_pkg::ISR_CMD_READ_EVENT);
    chk(r, 16'h1000);
  endtask

  task automatic t_sum();
    cmd(isr_pkg::ISR_CMD_WRITE_ENABLE, 16'hFFFF);
    ask(isr_pkg::ISR_CMD_READ_ENABLE);
    chk(r, 16'h3317);
    cmd(isr_pkg::ISR_CMD_WRITE_ENABLE, 16'h0010);
    ask(isr_pkg::ISR_CMD_READ_ENABLE);
    chk(r, 16'h0010);
    cmd(isr_pkg::ISR_CMD_WRITE_SRE, 16'h0080);
    st[3] = 1'b1;
    repeat (4) @(negedge CLK);
    chk({8'h00, STATUS_BYTE & 8'hC0}, 16'h00C0);
    chk({15'h0000, SERVICE_REQUEST}, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      ask(isr_pkg::ISR_CMD_READ_STB);
      chk(r & 16'hFFEF, 16'h00C0);
    end
    ask(isr_pkg::ISR_CMD_READ_EVENT);
    repeat (3) @(negedge CLK);
    chk({8'h00, STATUS_BYTE & 8'hC0}, 16'h0000);
    st[8] = 1'b1;
    repeat (3) @(negedge CLK);
    chk({8'h00, STATUS_BYTE & 8'hC2}, 16'h0002);
    cmd(isr_pkg::ISR_CMD_WRITE_SRE, 16'h0002);
    repeat (2) @(negedge CLK);
    chk({15'h0000, SERVICE_REQUEST}, 16'h0001);
    ask(isr_pkg::ISR_CMD_READ_SRE);
    chk(r, 16'h0002);
    st[8] = 1'b0;
    st[3] = 1'b0;
    repeat (3) @(negedge CLK);
    chk({15'h0000, SERVICE_REQUEST}, 16'h0000);
  endtask

  task automatic t_errq();
    for (int i = 1; i < 4; i++) push(16'h00C8 + 16'(i));
    @(negedge CLK);
    chk({8'h00, STATUS_BYTE & 8'h04}, 16'h0004);
    ask(isr_pkg::ISR_CMD_READ_COND);
    chk(r, 16'h2000);
    cmd(isr_pkg::ISR_CMD_RESET, 16'h0000);
    for (int i = 1; i < 4; i++) begin
      ask(isr_pkg::ISR_CMD_READ_ERROR);
      chk(r, 16'h00C8 + 16'(i));
    end
    ask(isr_pkg::ISR_CMD_READ_COND);
    chk(r, 16'h0000);
    for (int i = 1; i < 23; i++) push(16'h0100 + 16'(i));
    for (int i = 1; i < 20; i++) begin
      ask(isr_pkg::ISR_CMD_READ_ERROR);
      chk(r, 16'h0100 + 16'(i));
    end
    ask(isr_pkg::ISR_CMD_READ_ERROR);
    chk(r, 16'hFEA2);
    ask(isr_pkg::ISR_CMD_READ_ERROR);
    chk(r, 16'h0000);
  endtask

  // Stalling the controller lets the output queue fill until it drops an answer.
  task automatic t_mav();
    int n;
    hold = 1'b1;
    for (int i = 0; i < 9; i++) cmd(isr_pkg::ISR_CMD_READ_ENABLE, 16'h0000);
    repeat (3) @(negedge CLK);
    chk({8'h00, STATUS_BYTE & 8'h10}, 16'h0010);
    chk({15'h0000, OUT_VALID}, 16'h0001);
    n = resp_count;
    hold = 1'b0;
    repeat (60) @(negedge CLK);
    chk(16'(resp_count - n), 16'h0008);
    chk(resp_data, 16'h0010);
    chk({15'h0000, OUT_VALID}, 16'h0000);
    chk({8'h00, STATUS_BYTE & 8'h10}, 16'h0000);
  endtask

  task automatic t_set();
    cmd(isr_pkg::ISR_CMD_SET_DURATION, 16'h0010);
    cmd(isr_pkg::ISR_CMD_SET_INTERVAL, 16'h0002);
    cmd(isr_pkg::ISR_CMD_SET_FLAGS, 16'h000E);
    cmd(isr_pkg::ISR_CMD_SET_IFACE, 16'h0000);
    cmd(isr_pkg::ISR_CMD_SET_NET, 16'h0000);
    @(negedge CLK);
    chk(TEST_DURATION, 16'h0010);
    chk(TEST_INTERVAL, 16'h0002);
    chk(flags, 16'h000E);
    chk({13'h0000, IFACE_PENDING}, 16'h0000);
    chk({13'h0000, IFACE_ACTIVE}, 16'h0005);
    chk({14'h0000, NET_ACTIVE}, 16'h0003);
    cmd(isr_pkg::ISR_CMD_NET_RESTART, 16'h0000);
    @(negedge CLK);
    chk({14'h0000, NET_ACTIVE}, 16'h0000);
    cmd(isr_pkg::ISR_CMD_RESET, 16'h0000);
    @(negedge CLK);
    chk(TEST_DURATION, 16'h012C);
    chk(TEST_INTERVAL, 16'h0001);
    chk(flags, 16'h0001);
    chk({13'h0000, IFACE_ACTIVE}, 16'h0005);
    chk({14'h0000, NET_ACTIVE}, 16'h0000);
    push(16'h00E6);
    nv_iface = 3'h2;
    NRST = 1'b0;
    @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    chk({13'h0000, IFACE_ACTIVE}, 16'h0002);
    ask(isr_pkg::ISR_CMD_READ_ERROR);
    chk(r, 16'h0000);
  endtask

  initial begin
    {NRST, cmd_valid, err_push, hold, st} = '0;
    cmd_code = isr_pkg::ISR_CMD_NOP;
    {cmd_data, err_code} = '0;
    nv_iface = 3'h5;
    repeat (8) @(negedge CLK);
    NRST = 1'b1;
    repeat (3) @(negedge CLK);
    t_reset();
    t_oper();
    t_sum();
    t_errq();
    t_mav();
    t_set();
    conclude();
  end
endmodule
`default_nettype wire
